// ===== rtl/pcu_top.sv
// Function
// - first capture goes to start index
// - capture count sets number of captures
// - values are signed 32-bit pulse counts
// - bit 1 rebases axis after first capture
// - option bits are off after reset
// - done output rises on last capture
// - arming clears the done output
// - arming with zero count clears bit 0
// - last entry is start plus count minus one
// - each accepted trigger (armed, outside the hold-off) stores the next entry
// - count decrements once per capture
// - bit 0 clears after last capture
// - rebase makes capture relative, else the last rebase offset is kept (absolute until the first rebase)
// - compare checks axis against array value
// - compare output asserts one cycle after hit
// - compare source selectable and shown
// - capture source locked when compare uses it
// - selected edge and polarity trigger captures
// - minimum interval between accepted triggers
// - arming with nonzero count forces input configuration to 0x0100
// - capture source selectable and shown
`timescale 1ns/1ns
`default_nettype none
module pcu_top
    import pcu_pkg::*;
(
    input  wire logic        pclk,                // System clock, 100 MHz.
    input  wire logic        presetn,             // Asynchronous reset, active low.
    input  wire logic [11:0] paddr,               // APB byte address.
    input  wire logic        psel,                // APB select.
    input  wire logic        penable,             // APB access phase.
    input  wire logic        pwrite,              // APB write.
    input  wire logic [31:0] pwdata,              // APB write data.
    output logic      [31:0] prdata,              // APB read data.
    output logic             pready,              // APB ready.
    output logic             pslverr,             // APB error, unmapped address.
    input  wire pcu_axes_t   axes,                // Source axis positions.
    input  wire logic        fast_trigger_input,  // Fast capture pin.
    output logic             capture_done_output, // All captures stored.
    output logic             fast_compare_output, // Compare hit pulse.
    output logic             post_capture_start,  // Path launch pulse.
    output logic      [7:0]  post_capture_path    // Path number launched.
);

    // ---------------------------------------------------------------------
    // State
    // ---------------------------------------------------------------------
    logic [31:0]           cap_mem [PCU_ARRAY_DEPTH];
    pcu_state_t            state;
    logic [3:1]            ctrl_opt;
    logic [PCU_IDX_W-1:0]  start_idx;
    logic [PCU_IDX_W-1:0]  count;
    logic [PCU_IDX_W-1:0]  wr_ptr;
    logic [PCU_IDX_W-1:0]  cmp_idx;
    logic [PCU_IDX_W-1:0]  arr_idx;
    logic                  first;
    logic signed [31:0]    rebase;
    logic signed [31:0]    axis_ofs;
    pcu_src_t              cap_src;
    pcu_src_t              cmp_src;
    logic                  trig_pol;
    logic [15:0]           interval_us;
    logic [15:0]           input_cfg;
    logic                  cmp_active;
    logic                  trig_ok;
    logic                  hit;
    logic signed [31:0]    src_pos;
    logic signed [31:0]    cap_axis;
    logic signed [31:0]    cmp_pos;
    logic signed [31:0]    cap_value;
    logic                  wr;
    logic                  arm_req;
    logic                  last_cap;
    logic [31:0]           next_prdata;
    logic                  next_pslverr;

    // Picks one source axis; the capture axis is passed in for the compare side.
    function automatic logic signed [31:0] pcu_pick(input pcu_axes_t a, input pcu_src_t s,
                                                     input logic signed [31:0] cap);
        case (s)
            PCU_SRC_MOTOR: pcu_pick = a.motor;
            PCU_SRC_SCALE: pcu_pick = a.scale;
            PCU_SRC_PULSE: pcu_pick = a.pulse;
            default:       pcu_pick = cap;
        endcase
    endfunction : pcu_pick

    assign src_pos   = pcu_pick(axes, cap_src, 32'sh0);
    assign cap_axis  = src_pos + axis_ofs;
    assign cmp_pos   = pcu_pick(axes, cmp_src, cap_axis);
    assign wr        = psel && penable && pready && pwrite;
    assign arm_req   = wr && paddr == PCU_OFF_CTRL && pwdata[PCU_CTRL_ARM];
    assign last_cap  = trig_ok && count == 10'h001;
    // The first point reads as the rebase value when rebasing is on.
    assign cap_value = (first && ctrl_opt[PCU_CTRL_REBASE]) ? rebase : cap_axis;

    // ---------------------------------------------------------------------
    // Trigger qualification and compare
    // ---------------------------------------------------------------------
    pcu_trig_qual u_trig (
        .pclk        (pclk),
        .presetn     (presetn),
        .trig_in     (fast_trigger_input),
        .active_low  (trig_pol),
        .interval_us (interval_us),
        .armed       (state == PCU_ARMED),
        .trig_ok     (trig_ok)
    );

    pcu_cmp u_cmp (
        .pclk    (pclk),
        .presetn (presetn),
        .active  (cmp_active),
        .pos     (cmp_pos),
        .target  (cap_mem[cmp_idx]),
        .hit     (hit)
    );

    // ---------------------------------------------------------------------
    // APB slave
    // ---------------------------------------------------------------------
    always_comb begin
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        case (paddr)
            PCU_OFF_CTRL:    next_prdata = {28'h0, ctrl_opt, state == PCU_ARMED};
            PCU_OFF_START:   next_prdata = {22'h0, start_idx};
            PCU_OFF_COUNT:   next_prdata = {22'h0, count};
            PCU_OFF_CAPPOS:  next_prdata = cap_axis;
            PCU_OFF_REBASE:  next_prdata = rebase;
            PCU_OFF_CAPSRC:  next_prdata = {30'h0, cap_src};
            PCU_OFF_CMPSRC:  next_prdata = {30'h0, cmp_src};
            PCU_OFF_CMPPOS:  next_prdata = cmp_pos;
            PCU_OFF_TRIGCFG: next_prdata = {15'h0, trig_pol, interval_us};
            PCU_OFF_INCFG:   next_prdata = {16'h0, input_cfg};
            PCU_OFF_CMPCTRL: next_prdata = {21'h0, cmp_idx, cmp_active};
            PCU_OFF_ARRIDX:  next_prdata = {22'h0, arr_idx};
            PCU_OFF_ARRDATA: next_prdata = cap_mem[arr_idx];
            PCU_OFF_STATUS:  next_prdata = {21'h0, wr_ptr, capture_done_output};
            default:         next_pslverr = 1'b1;
        endcase
    end

    // One wait-free access: data are loaded in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            prdata  <= (psel && !penable && !pwrite) ? next_prdata : 32'h0000_0000;
            pslverr <= psel && !penable && next_pslverr;
        end
    end

    // ---------------------------------------------------------------------
    // Configuration registers
    // ---------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_opt    <= PCU_CTRL_RESET[3:1];
            start_idx   <= '0;
            rebase      <= 32'sh0;
            cap_src     <= PCU_SRC_MOTOR;
            cmp_src     <= PCU_SRC_MOTOR;
            trig_pol    <= 1'b0;
            interval_us <= 16'h0000;
            cmp_idx     <= '0;
            arr_idx     <= '0;
        end else if (wr) begin
            case (paddr)
                PCU_OFF_CTRL:    ctrl_opt  <= pwdata[3:1];
                PCU_OFF_START:   start_idx <= pwdata[PCU_IDX_W-1:0];
                PCU_OFF_REBASE:  rebase    <= pwdata;
                PCU_OFF_CAPSRC: begin
                    // The capture axis may not feed itself, nor move under the compare unit.
                    if (cmp_src != PCU_SRC_CAPTURE && pwdata[1:0] != 2'h3) begin
                        cap_src <= pcu_src_t'(pwdata[1:0]);
                    end
                end
                PCU_OFF_CMPSRC:  cmp_src   <= pcu_src_t'(pwdata[1:0]);
                PCU_OFF_TRIGCFG: begin
                    trig_pol    <= pwdata[PCU_TRIG_POL];
                    interval_us <= pwdata[15:0];
                end
                PCU_OFF_CMPCTRL: cmp_idx   <= pwdata[PCU_IDX_W:1];
                PCU_OFF_ARRIDX:  arr_idx   <= pwdata[PCU_IDX_W-1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_cfg <= PCU_INCFG_RESET;
        end else if (arm_req && count != 10'h000) begin
            input_cfg <= PCU_INCFG_FORCED;
        end else if (wr && paddr == PCU_OFF_INCFG) begin
            input_cfg <= pwdata[15:0];
        end
    end

    // ---------------------------------------------------------------------
    // Capture sequencing
    // ---------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= PCU_IDLE;
        end else begin
            case (state)
                PCU_IDLE: begin
                    if (arm_req && count != 10'h000) begin
                        state <= PCU_ARMED;
                    end
                end
                PCU_ARMED: begin
                    if (last_cap) begin
                        state <= PCU_IDLE;
                    end else if (wr && paddr == PCU_OFF_CTRL && !pwdata[PCU_CTRL_ARM]) begin
                        state <= PCU_IDLE;
                    end
                end
                default: state <= PCU_IDLE;
            endcase
        end
    end

    // A capture is written and counted in the cycle it is accepted.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count  <= '0;
            wr_ptr <= '0;
            first  <= 1'b0;
        end else if (trig_ok) begin
            count  <= count - 10'h001;
            wr_ptr <= wr_ptr + 10'h001;
            first  <= 1'b0;
        end else if (arm_req && state == PCU_IDLE) begin
            wr_ptr <= start_idx;
            first  <= 1'b1;
        end else if (wr && paddr == PCU_OFF_COUNT) begin
            count  <= pwdata[PCU_IDX_W-1:0];
        end
    end

    always_ff @(posedge pclk) begin
        if (trig_ok) begin
            cap_mem[wr_ptr] <= cap_value;
        end else if (wr && paddr == PCU_OFF_ARRDATA) begin
            cap_mem[arr_idx] <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            axis_ofs <= 32'sh0;
        end else if (trig_ok && first && ctrl_opt[PCU_CTRL_REBASE]) begin
            axis_ofs <= rebase - src_pos;
        end
    end

    // Done is set by the last capture, which wins over a same-cycle arm.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_done_output <= 1'b0;
        end else if (last_cap) begin
            capture_done_output <= 1'b1;
        end else if (arm_req) begin
            capture_done_output <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            post_capture_start <= 1'b0;
            post_capture_path  <= 8'h00;
        end else begin
            post_capture_start <= last_cap && ctrl_opt[PCU_CTRL_PATH];
            post_capture_path  <= PCU_PATH_NUMBER;
        end
    end

    // ---------------------------------------------------------------------
    // Compare control
    // ---------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_active <= 1'b0;
        end else if (trig_ok && first && ctrl_opt[PCU_CTRL_AUTOCMP]) begin
            cmp_active <= 1'b1;
        end else if (wr && paddr == PCU_OFF_CMPCTRL) begin
            cmp_active <= pwdata[0];
        end else if (hit) begin
            cmp_active <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_compare_output <= 1'b0;
        end else begin
            fast_compare_output <= hit;
        end
    end

    // ---------------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------------
    sequence s_arm_zero;
        arm_req && state == PCU_IDLE && count == 10'h000;
    endsequence

    property p_arm_zero;
        @(posedge pclk) disable iff (!presetn)
        s_arm_zero |=> state == PCU_IDLE && !capture_done_output;
    endproperty
    a_arm_zero: assert property (p_arm_zero) else $error("Zero-count arm did not stay idle.");

    property p_last;
        @(posedge pclk) disable iff (!presetn)
        last_cap |=> capture_done_output && state == PCU_IDLE && count == 10'h000;
    endproperty
    a_last: assert property (p_last) else $error("Last capture did not finish the run.");

    property p_store;
        @(posedge pclk) disable iff (!presetn)
        trig_ok |=> cap_mem[$past(wr_ptr)] == $past(cap_value) && count == $past(count) - 10'h001;
    endproperty
    a_store: assert property (p_store) else $error("Capture not stored or not counted.");

    property p_first_idx;
        @(posedge pclk) disable iff (!presetn)
        arm_req && state == PCU_IDLE && count != 10'h000 |=> wr_ptr == $past(start_idx) && first;
    endproperty
    a_first_idx: assert property (p_first_idx) else $error("Arm did not load start index.");

    property p_rebase;
        @(posedge pclk) disable iff (!presetn)
        trig_ok && first && ctrl_opt[PCU_CTRL_REBASE] && $stable(src_pos) ##1 $stable(src_pos)
            |-> cap_axis == $past(rebase);
    endproperty
    a_rebase: assert property (p_rebase) else $error("Axis not rebased after first point.");

    property p_lock;
        @(posedge pclk) disable iff (!presetn)
        cmp_src == PCU_SRC_CAPTURE |=> $stable(cap_src);
    endproperty
    a_lock: assert property (p_lock) else $error("Capture source changed while locked.");

    property p_cmp_out;
        @(posedge pclk) disable iff (!presetn)
        hit |=> fast_compare_output && !cmp_active;
    endproperty
    a_cmp_out: assert property (p_cmp_out) else $error("Compare hit not driven out.");

endmodule : pcu_top
`default_nettype wire

// ===== rtl/pcu_pkg.sv
package pcu_pkg;

    // ---------------------------------------------------------------------
    // Data array and register map
    // ---------------------------------------------------------------------
    localparam int          PCU_ARRAY_DEPTH  = 800;
    localparam int          PCU_IDX_W        = 10;
    localparam logic [11:0] PCU_OFF_CTRL     = 12'h000;
    localparam logic [11:0] PCU_OFF_START    = 12'h004;
    localparam logic [11:0] PCU_OFF_COUNT    = 12'h008;
    localparam logic [11:0] PCU_OFF_CAPPOS   = 12'h00c;
    localparam logic [11:0] PCU_OFF_REBASE   = 12'h010;
    localparam logic [11:0] PCU_OFF_CAPSRC   = 12'h014;
    localparam logic [11:0] PCU_OFF_CMPSRC   = 12'h018;
    localparam logic [11:0] PCU_OFF_CMPPOS   = 12'h01c;
    localparam logic [11:0] PCU_OFF_TRIGCFG  = 12'h020;
    localparam logic [11:0] PCU_OFF_INCFG    = 12'h024;
    localparam logic [11:0] PCU_OFF_CMPCTRL  = 12'h028;
    localparam logic [11:0] PCU_OFF_ARRIDX   = 12'h02c;
    localparam logic [11:0] PCU_OFF_ARRDATA  = 12'h030;
    localparam logic [11:0] PCU_OFF_STATUS   = 12'h034;

    // ---------------------------------------------------------------------
    // Field positions and reset values
    // ---------------------------------------------------------------------
    localparam int          PCU_CTRL_ARM     = 0;
    localparam int          PCU_CTRL_REBASE  = 1;
    localparam int          PCU_CTRL_AUTOCMP = 2;
    localparam int          PCU_CTRL_PATH    = 3;
    localparam logic [3:0]  PCU_CTRL_RESET   = 4'h0;
    localparam int          PCU_TRIG_POL     = 16;
    localparam logic [15:0] PCU_INCFG_FORCED = 16'h0100;
    localparam logic [15:0] PCU_INCFG_RESET  = 16'h0000;
    localparam logic [7:0]  PCU_PATH_NUMBER  = 8'h32;

    // ---------------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------------
    localparam int          PCU_CLK_NS       = 10;
    localparam int          PCU_TICK_NS      = 1000;
    localparam logic [6:0]  PCU_TICK_CYCLES  = 7'(PCU_TICK_NS / PCU_CLK_NS);

    // ---------------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------------
    typedef enum logic [1:0] {PCU_SRC_MOTOR, PCU_SRC_SCALE, PCU_SRC_PULSE, PCU_SRC_CAPTURE} pcu_src_t;
    typedef enum logic {PCU_IDLE, PCU_ARMED} pcu_state_t;

    typedef struct packed {
        logic signed [31:0] motor;
        logic signed [31:0] scale;
        logic signed [31:0] pulse;
    } pcu_axes_t;

endpackage : pcu_pkg

// ===== rtl/pcu_trig_qual.sv
`timescale 1ns/1ns
`default_nettype none
module pcu_trig_qual
    import pcu_pkg::*;
(
    input  wire logic        pclk,        // System clock.
    input  wire logic        presetn,     // Asynchronous reset, active low.
    input  wire logic        trig_in,     // Fast trigger pin level.
    input  wire logic        active_low,  // Normally-closed contact.
    input  wire logic [15:0] interval_us, // Hold-off after a capture.
    input  wire logic        armed,       // Capture is armed.
    output logic             trig_ok      // Accepted trigger, one cycle.
);

    logic       prev_lvl;
    logic [6:0] div;
    logic       tick;
    logic [15:0] hold;
    logic       lvl;

    assign lvl     = trig_in ^ active_low;
    assign tick    = (div == 7'h00);
    assign trig_ok = armed && lvl && !prev_lvl && (hold == 16'h0000);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_lvl <= 1'b0;
        end else begin
            prev_lvl <= lvl;
        end
    end

    // Restarting the divider on each capture makes the hold-off a full interval, never a tick short.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= 7'h00;
        end else if (tick || trig_ok) begin
            div <= PCU_TICK_CYCLES - 7'h01;
        end else begin
            div <= div - 7'h01;
        end
    end

    // Hold-off window after each accepted trigger, counted in microseconds.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold <= 16'h0000;
        end else if (trig_ok) begin
            hold <= interval_us;
        end else if (tick && hold != 16'h0000) begin
            hold <= hold - 16'h0001;
        end
    end

    property p_holdoff;
        @(posedge pclk) disable iff (!presetn)
        trig_ok && interval_us != 16'h0000 |=> !trig_ok [*8];
    endproperty
    a_holdoff: assert property (p_holdoff) else $error("Trigger accepted inside hold-off.");

    property p_unarmed;
        @(posedge pclk) disable iff (!presetn)
        !armed |-> !trig_ok;
    endproperty
    a_unarmed: assert property (p_unarmed) else $error("Trigger accepted while disarmed.");

endmodule : pcu_trig_qual
`default_nettype wire

// ===== rtl/pcu_cmp.sv
`timescale 1ns/1ns
`default_nettype none
module pcu_cmp
    import pcu_pkg::*;
(
    input  wire logic               pclk,    // System clock.
    input  wire logic               presetn, // Asynchronous reset, active low.
    input  wire logic               active,  // Compare unit running.
    input  wire logic signed [31:0] pos,     // Selected axis position.
    input  wire logic signed [31:0] target,  // Value from the data array.
    output logic                    hit      // Position passed the target.
);

    logic signed [31:0] prev_pos;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_pos <= 32'sh0;
        end else begin
            prev_pos <= pos;
        end
    end

    // A pass in either direction counts, as does landing exactly on it.
    assign hit = active && ((prev_pos < target && pos >= target) ||
                            (prev_pos > target && pos <= target) ||
                            (pos == target));

    property p_hit_cause;
        @(posedge pclk) disable iff (!presetn)
        hit |-> active && (pos == target || (($past(pos) < target) != (pos < target)));
    endproperty
    a_hit_cause: assert property (p_hit_cause) else $error("Compare hit without a crossing.");

endmodule : pcu_cmp
`default_nettype wire

// ===== testbench/pcu_sensor_model.sv
`timescale 1ns/1ns
`default_nettype none
module pcu_sensor_model
    import pcu_pkg::*;
(
    input  wire logic pclk, // System clock.
    output var pcu_axes_t axes, // Encoder positions.
    output logic      trig  // Fast trigger pin.
);
    initial begin
        axes = '0;
        trig = 1'b0;
    end
    // Moves the axes, then gives one clean edge with a low level after it.
    task automatic hit(input logic signed [31:0] pos);
        @(posedge pclk);
        axes <= '{pos, pos + 32'sd7, pos - 32'sd7};
        repeat (2) @(posedge pclk);
        trig <= 1'b1;
        repeat (3) @(posedge pclk);
        trig <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask : hit
endmodule : pcu_sensor_model
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import pcu_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, trig, done, er, pstart, cmpo;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  pnum;
    pcu_axes_t   axes;
    int          err_total, checks, starts, cmps, i;

    pcu_sensor_model m (.pclk(pclk), .axes(axes), .trig(trig));
    pcu_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .axes(axes), .fast_trigger_input(trig), .capture_done_output(done),
        .fast_compare_output(cmpo), .post_capture_start(pstart), .post_capture_path(pnum));

    always #5 pclk = ~pclk;
    always @(posedge pclk) if (pstart === 1'b1) starts++;
    always @(posedge pclk) if (cmpo === 1'b1) cmps++;

    task automatic end_sim;
        if (err_total == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc

    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(PCU_OFF_CTRL, 32'h0);
        rdc(PCU_OFF_INCFG, 32'h0);
        apb(1'b0, 12'h040, 32'h0);
        chk({31'h0, er}, 32'h1);
        wr(PCU_OFF_COUNT, 32'h0);
        wr(PCU_OFF_CTRL, 32'h1);
        rdc(PCU_OFF_CTRL, 32'h0);
        chk({31'h0, done}, 32'h0);
        wr(PCU_OFF_ARRIDX, 32'h8);
        wr(PCU_OFF_ARRDATA, 32'h5a5a);
        m.hit(32'sd9);
        rdc(PCU_OFF_ARRDATA, 32'h5a5a);
        wr(PCU_OFF_START, 32'h5);
        wr(PCU_OFF_COUNT, 32'h3);
        wr(PCU_OFF_TRIGCFG, 32'h0);
        wr(PCU_OFF_CTRL, 32'h1);
        rdc(PCU_OFF_INCFG, 32'h100);
        for (i = 0; i < 3; i++) begin
            m.hit(100 * (i + 1));
            rdc(PCU_OFF_COUNT, 32'(2 - i));
        end
        rdc(PCU_OFF_CTRL, 32'h0);
        chk({31'h0, done}, 32'h1);
        for (i = 0; i < 4; i++) begin
            wr(PCU_OFF_ARRIDX, 32'(5 + i));
            rdc(PCU_OFF_ARRDATA, (i < 3) ? 32'(100 * (i + 1)) : 32'h5a5a);
        end
        wr(PCU_OFF_START, 32'd20);
        wr(PCU_OFF_REBASE, 32'hffff_fc18);
        wr(PCU_OFF_COUNT, 32'h2);
        wr(PCU_OFF_CTRL, 32'hb);
        chk({31'h0, done}, 32'h0);
        m.hit(-32'sd500);
        m.hit(-32'sd200);
        chk(32'(starts), 32'h1);
        chk({24'h0, pnum}, 32'h32);
        rdc(PCU_OFF_CAPPOS, 32'hffff_fd44);
        wr(PCU_OFF_ARRIDX, 32'd20);
        rdc(PCU_OFF_ARRDATA, 32'hffff_fc18);
        wr(PCU_OFF_ARRIDX, 32'd21);
        rdc(PCU_OFF_ARRDATA, 32'hffff_fd44);
        wr(PCU_OFF_CMPSRC, 32'h3);
        wr(PCU_OFF_CAPSRC, 32'h1);
        rdc(PCU_OFF_CAPSRC, 32'h0);
        rdc(PCU_OFF_CMPSRC, 32'h3);
        wr(PCU_OFF_CMPCTRL, 32'h2a);
        wr(PCU_OFF_TRIGCFG, 32'h1_0001);
        wr(PCU_OFF_START, 32'd30);
        wr(PCU_OFF_COUNT, 32'h2);
        wr(PCU_OFF_CTRL, 32'h5);
        m.hit(-32'sd100);
        rdc(PCU_OFF_CMPCTRL, 32'h2b);
        m.hit(32'sd100);
        rdc(PCU_OFF_COUNT, 32'h1);
        repeat (100) @(posedge pclk);
        m.hit(-32'sd300);
        rdc(PCU_OFF_CMPCTRL, 32'h2a);
        chk(32'(cmps), 32'h1);
        chk({31'h0, done}, 32'h1);
        wr(PCU_OFF_ARRIDX, 32'd30);
        rdc(PCU_OFF_ARRDATA, 32'hffff_fda8);
        wr(PCU_OFF_ARRIDX, 32'd31);
        rdc(PCU_OFF_ARRDATA, 32'hffff_fce0);
        end_sim();
    end
    initial begin
        #200000;
        err_total++;
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
